// ### sim/sme_engine_asserts.sv
// Checker of engine timing and byte placement
`timescale 1ns/1ps
`default_nettype none
module sme_engine_asserts (
  input wire logic       i_clk,         // Clock
  input wire logic       i_rst,         // Reset
  input wire logic       i_start,       // Start
  input wire logic       i_secret_mode, // Mode
  input wire logic       o_busy,        // Busy
  input wire logic       o_done,        // Done
  input wire logic       o_sp_we,       // Byte strobe
  input wire logic [4:0] o_sp_addr,     // Byte offset
  input wire logic [7:0] o_sp_data      // Byte data
);
  logic mode;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Mode of the run in progress
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) mode <= 1'b0;
    else if (i_start && !o_busy) mode <= i_secret_mode;
  end
  a_busy_start: assert property (i_start && !o_busy |=> o_busy)
    else $error("busy did not rise");
  a_rounds_gap: assert property (i_start && !o_busy |-> ##81 !o_sp_we ##1 o_sp_we)
    else $error("first byte not after 80 rounds");
  a_part_done: assert property (i_start && !o_busy && i_secret_mode |-> ##113 o_done)
    else $error("partial run length wrong");
  a_full_done: assert property (i_start && !o_busy && !i_secret_mode |-> ##101 o_done)
    else $error("full run length wrong");
  a_first_addr: assert property ($rose(o_sp_we) |-> o_sp_addr == (mode ? 5'h00 : 5'h08))
    else $error("first byte offset wrong");
  a_addr_step: assert property (o_sp_we && $past(o_sp_we) |-> o_sp_addr == $past(o_sp_addr) + 5'h01)
    else $error("byte offsets not consecutive");
  a_last_addr: assert property (o_done |-> o_sp_we && o_sp_addr == (mode ? 5'h1F : 5'h1B))
    else $error("last byte offset wrong");
  a_part_repeat: assert property (o_sp_we && mode && o_sp_addr >= 5'h08 |-> o_sp_data == $past(o_sp_data, 8))
    else $error("partial pattern does not repeat");
  a_done_idle: assert property (o_done |=> !o_busy && !o_sp_we)
    else $error("activity after done");
endmodule
bind sme_engine sme_engine_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start),
  .i_secret_mode(i_secret_mode), .o_busy(o_busy), .o_done(o_done), .o_sp_we(o_sp_we),
  .o_sp_addr(o_sp_addr), .o_sp_data(o_sp_data));
`default_nettype wire

// ### sim/sme_engine_tb.sv
// Self-checking bench of the authentication code engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module sme_engine_tb;
  import sme_pkg::*;
  logic         i_clk, i_rst, i_word_valid, i_start, i_secret_mode, clr, o_busy, o_done, o_sp_we;
  logic         i_first_secret;
  logic [3:0]   i_word_idx;
  logic [31:0]  word;
  logic [31:0]  msg [16];
  logic [4:0]   o_sp_addr;
  logic [7:0]   o_sp_data;
  logic [7:0]   mem [32];
  logic [159:0] o_mac, exp_mac;
  int           wr_cnt, n_mismatch, num_checks, cyc, tick;
  sme_engine u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_word_valid(i_word_valid),
    .i_word_idx(i_word_idx), .i_message_input_word(word), .i_start(i_start),
    .i_first_secret(i_first_secret),
    .i_secret_mode(i_secret_mode), .o_busy(o_busy), .o_done(o_done), .o_sp_we(o_sp_we),
    .o_sp_addr(o_sp_addr), .o_sp_data(o_sp_data), .o_mac(o_mac));
  sme_scratch_model u_sp (.i_clk(i_clk), .i_clr(clr), .i_we(o_sp_we), .i_addr(o_sp_addr),
    .i_data(o_sp_data), .o_mem(mem), .o_wr_cnt(wr_cnt));
  // Clock and hang limit
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    tick++;
    if (tick == 3000) begin
      n_mismatch++;
      close_out;
    end
  end
  // Reference hash of one block, no feed-forward
  function automatic logic [159:0] ref_mac(input logic [31:0] m [16]);
    logic [31:0] w [80];
    logic [31:0] a, b, c, d, e, f, k, t;
    {a, b, c, d, e} = {INIT_A, INIT_B, INIT_C, INIT_D, INIT_E};
    for (int i = 0; i < 80; i++) begin
      t = (i < 16) ? m[i] : (w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16]);
      w[i] = (i < 16) ? t : {t[30:0], t[31]};
      f = (i < 20) ? ((b & c) | (~b & d)) : (i >= 40 && i < 60) ? ((b & c) | (b & d) | (c & d))
        : (b ^ c ^ d);
      k = (i < 20) ? RC_CHOOSE : (i < 40) ? RC_PARITY1 : (i < 60) ? RC_MAJORITY : RC_PARITY2;
      t = {a[26:0], a[31:27]} + f + w[i] + k + e;
      {a, b, c, d, e} = {t, a, {b[1:0], b[31:2]}, c, d};
    end
    return {a, b, c, d, e};
  endfunction
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask
  // Load all sixteen words
  task automatic load;
    for (int i = 0; i < 16; i++) begin
      i_word_valid = 1'b1;
      i_word_idx = i[3:0];
      word = msg[i];
      step;
    end
    i_word_valid = 1'b0;
  endtask
  // One computation; a word and a start are offered while busy and must be ignored
  task automatic run(input logic mode, input logic first);
    logic [31:0] m [16];
    logic [7:0]  exp_b;
    m = msg;
    if (first) begin
      m[0] = 32'h00000000;
      m[12] = 32'h00000000;
    end
    exp_mac = ref_mac(m);
    clr = 1'b1;
    step;
    clr = 1'b0;
    i_secret_mode = mode;
    i_first_secret = first;
    i_start = 1'b1;
    step;
    i_start = 1'b0;
    `CHK("busy", 1'b1, o_busy)
    word = ~msg[0];
    i_word_idx = 4'h0;
    cyc = 1;
    while (o_done !== 1'b1 && cyc < 200) begin
      i_word_valid = (cyc == 5);
      i_start = (cyc == 5);
      step;
      cyc++;
    end
    `CHK("done cycle", mode ? 113 : 101, cyc)
    `CHK("busy end", 1'b0, o_busy)
    step;
    `CHK("done pulse", 1'b0, o_done)
    `CHK("mac", exp_mac, o_mac)
    `CHK("writes", mode ? 32 : 20, wr_cnt)
    for (int i = 0; i < 32; i++) begin
      exp_b = (i >= 8 && i < 28) ? exp_mac[(i - 8) * 8 +: 8] : 8'hC3;
      if (mode) exp_b = exp_mac[(i % 8) * 8 +: 8];
      `CHK("sp byte", exp_b, mem[i])
    end
  endtask
  task automatic t_full_pad;
    for (int i = 0; i < 16; i++) msg[i] = 32'h00000000;
    msg[0] = 32'h61626380;
    msg[15] = 32'h00000018;
    load;
    run(1'b0, 1'b0);
  endtask
  task automatic t_part_keep;
    run(1'b1, 1'b0);
  endtask
  // Carry-heavy words; the first-secret run must leave the stored words intact
  task automatic t_carry_pair;
    for (int i = 0; i < 16; i++) msg[i] = 32'hFFFFFFF0 | i;
    load;
    run(1'b0, 1'b0);
    run(1'b1, 1'b1);
    run(1'b1, 1'b0);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset then scenarios
  initial begin
    {i_rst, i_word_valid, i_start, i_secret_mode, clr, i_word_idx, word} = '0;
    i_first_secret = 1'b0;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1 i_rst = 1'b0;
    t_full_pad;
    t_part_keep;
    t_carry_pair;
    close_out;
  end
endmodule
`default_nettype wire

// ### sim/sme_scratch_model.sv
// Scratchpad model recording the engine's byte writes
`timescale 1ns/1ps
`default_nettype none
module sme_scratch_model (
  input  wire logic       i_clk,      // Clock
  input  wire logic       i_clr,      // Fill with blank pattern
  input  wire logic       i_we,       // Byte strobe
  input  wire logic [4:0] i_addr,     // Byte offset
  input  wire logic [7:0] i_data,     // Byte data
  output var  logic [7:0] o_mem [32], // Stored bytes
  output var  int         o_wr_cnt    // Writes since clear
);
  // Byte store, blank pattern shows untouched offsets
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      for (int i = 0; i < 32; i++) o_mem[i] <= 8'hC3;
      o_wr_cnt <= 0;
    end else if (i_we) begin
      o_mem[i_addr] <= i_data;
      o_wr_cnt <= o_wr_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### src/sme_engine.sv
// SHA-1 authentication code engine: load, 80 rounds, scratchpad write-back
`timescale 1ns/1ps
`default_nettype none
module sme_engine
  import sme_pkg::*;
(
  input  wire logic        i_clk,          // System clock, 10 MHz
  input  wire logic        i_rst,          // Asynchronous reset, high
  input  wire logic        i_word_valid,   // Message word strobe
  input  wire logic [3:0]  i_word_idx,     // Message word index 0..15
  input  wire logic [31:0] i_message_input_word, // Message word data
  input  wire logic        i_start,        // Start pulse
  input  wire logic        i_secret_mode,  // 1: partial repeated code
  input  wire logic        i_first_secret, // 1: secret words read as zero
  output logic             o_busy,         // Engine running
  output logic             o_done,         // One-cycle completion pulse
  output logic             o_sp_we,        // Scratchpad byte write strobe
  output logic [4:0]       o_sp_addr,      // Scratchpad byte offset
  output logic [7:0]       o_sp_data,      // Scratchpad byte data
  output logic [159:0]     o_mac           // Final code A..E
);
  sme_msg_if msg ();

  sme_state_t  state, next_state;
  logic [31:0] a, b, c, d, e, next_a, next_b, next_c, next_d, next_e;
  logic [31:0] w [MSG_WORDS];
  logic [31:0] next_w [MSG_WORDS];
  logic [6:0]  rnd, next_rnd;
  logic        mode, next_mode;
  // Run reads the two secret words as zero
  logic        first, next_first;
  logic        busy, next_busy, done, next_done;
  logic        we, next_we;
  logic [4:0]  addr, next_addr;
  logic [7:0]  data, next_data;
  logic [159:0] mac, next_mac;
  logic [31:0] round_temp_sum, wt, fval, kval;

  // Left rotate within a word; n stays between 1 and 31 at every use
  function automatic logic [31:0] rotl(input logic [31:0] x, input int unsigned n);
    rotl = (x << n) | (x >> (WORD_W - n));
  endfunction

  // Byte of the result for a scratchpad offset in either layout
  function automatic logic [7:0] out_byte(input logic [159:0] m, input logic [4:0] ad,
                                          input logic pm);
    logic [4:0] rel;
    logic [2:0] wsel;
    rel = ad - FULL_FIRST;
    wsel = pm ? {2'b00, ad[2]} : 3'(rel[4:2]);
    out_byte = 8'h00;
    case (wsel)
      3'd0: out_byte = m[8*ad[1:0] +: 8];          // E
      3'd1: out_byte = m[32 + 8*ad[1:0] +: 8];     // D
      3'd2: out_byte = m[64 + 8*ad[1:0] +: 8];     // C
      3'd3: out_byte = m[96 + 8*ad[1:0] +: 8];     // B
      3'd4: out_byte = m[128 + 8*ad[1:0] +: 8];    // A
      default: out_byte = 8'h00;
    endcase
  endfunction

  // Message words land in the word memory only while idle; words offered
  // during a run are dropped so the stored block survives for the next start
  assign msg.wr_en   = i_word_valid && (state == SME_IDLE);
  assign msg.wr_idx  = i_word_idx;
  assign msg.wr_data = i_message_input_word;
  // Read index runs one round ahead because the memory read is registered
  assign msg.rd_idx  = next_rnd[3:0];

  sme_word_mem u_mem (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .bus   (msg)
  );

  // Round word, function, constant and temporary sum; rounds 0-15 take the
  // stored words straight from the memory, except that a first-secret run takes zero
  // at rounds 0 and 12, and the rolling window collects them so that from round 16
  // it holds the last sixteen schedule words
  always_comb begin
    if (rnd < RND_MSG) begin
      wt = msg.rd_data;
      if (first && (rnd == SECRET_LO || rnd == SECRET_HI)) begin
        wt = 32'h00000000;
      end
    end else begin
      wt = rotl(w[13] ^ w[8] ^ w[2] ^ w[0], 1);
    end
    if (rnd < RND_G1) begin
      fval = (b & c) | (~b & d);
      kval = RC_CHOOSE;
    end else if (rnd < RND_G2) begin
      fval = b ^ c ^ d;
      kval = RC_PARITY1;
    end else if (rnd < RND_G3) begin
      fval = (b & c) | (b & d) | (c & d);
      kval = RC_MAJORITY;
    end else begin
      fval = b ^ c ^ d;
      kval = RC_PARITY2;
    end
    round_temp_sum = rotl(a, 5) + fval + wt + kval + e;
  end

  // Next-state logic for the whole engine
  always_comb begin
    // Hold everything except done and the write strobe, which default low, unless a state below moves it
    next_state = state;
    next_a = a;
    next_b = b;
    next_c = c;
    next_d = d;
    next_e = e;
    for (int i = 0; i < MSG_WORDS; i++) next_w[i] = w[i];
    next_rnd = rnd;
    next_mode = mode;
    next_first = first;
    next_busy = busy;
    next_done = 1'b0;
    next_we = 1'b0;
    next_addr = addr;
    next_data = data;
    next_mac = mac;
    case (state)
      SME_IDLE: begin
        if (i_start) begin
          // Chaining values restart from the fixed constants on every run
          next_a = INIT_A;
          next_b = INIT_B;
          next_c = INIT_C;
          next_d = INIT_D;
          next_e = INIT_E;
          next_rnd = 7'd0;
          next_mode = i_secret_mode;
          next_first = i_first_secret;
          next_busy = 1'b1;
          next_state = SME_ROUND;
        end
      end
      SME_ROUND: begin
        // Window drops its oldest word and takes this round's word
        for (int i = 0; i < MSG_WORDS - 1; i++) next_w[i] = w[i+1];
        next_w[MSG_WORDS-1] = wt;
        next_e = d;
        next_d = c;
        next_c = rotl(b, 30);
        next_b = a;
        next_a = round_temp_sum;
        next_rnd = rnd + 7'd1;
        if (rnd == RND_LAST) begin
          next_mac = {round_temp_sum, a, rotl(b, 30), c, d};
          next_addr = mode ? 5'h00 : FULL_FIRST;
          next_state = SME_WRITE;
        end
      end
      SME_WRITE: begin
        next_we = 1'b1;
        next_data = out_byte(mac, addr, mode);
        next_addr = addr + 5'd1;
        // Done and the last byte leave together; busy drops at the same edge
        if (addr == (mode ? PART_LAST : FULL_LAST)) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = SME_IDLE;
        end
      end
      default: next_state = SME_IDLE;
    endcase
  end

  // Registers; the write address output lags one cycle behind addr
  // so that it lines up with the byte computed from addr in the same cycle
  logic [4:0] sp_addr_q, next_sp_addr;
  assign next_sp_addr = addr;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SME_IDLE;
      a <= 32'h0;
      b <= 32'h0;
      c <= 32'h0;
      d <= 32'h0;
      e <= 32'h0;
      for (int i = 0; i < MSG_WORDS; i++) w[i] <= 32'h0;
      rnd <= 7'h0;
      mode <= 1'b0;
      first <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      we <= 1'b0;
      addr <= 5'h0;
      sp_addr_q <= 5'h0;
      data <= 8'h0;
      mac <= 160'h0;
    end else begin
      state <= next_state;
      a <= next_a;
      b <= next_b;
      c <= next_c;
      d <= next_d;
      e <= next_e;
      for (int i = 0; i < MSG_WORDS; i++) w[i] <= next_w[i];
      rnd <= next_rnd;
      mode <= next_mode;
      first <= next_first;
      busy <= next_busy;
      done <= next_done;
      we <= next_we;
      addr <= next_addr;
      sp_addr_q <= next_sp_addr;
      data <= next_data;
      mac <= next_mac;
    end
  end

  // Outputs straight from flip-flops
  assign o_busy    = busy;
  assign o_done    = done;
  assign o_sp_we   = we;
  assign o_sp_addr = sp_addr_q;
  assign o_sp_data = data;
  assign o_mac     = mac;
endmodule
`default_nettype wire

// ### src/sme_msg_if.sv
// Interface carrying the message word window between engine and word memory
`timescale 1ns/1ps
`default_nettype none
interface sme_msg_if;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [31:0] wr_data;
  logic [3:0]  rd_idx;
  logic [31:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ### src/sme_pkg.sv
// Package of constants and types for the SHA-1 authentication code engine
package sme_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned MSG_WORDS   = 16;
  localparam int unsigned ROUNDS      = 80;
  localparam int unsigned SP_BYTES    = 32;
  localparam int unsigned SP_ADDR_W   = 5;
  localparam logic [31:0] INIT_A      = 32'h67452301;
  localparam logic [31:0] INIT_B      = 32'hEFCDAB89;
  localparam logic [31:0] INIT_C      = 32'h98BADCFE;
  localparam logic [31:0] INIT_D      = 32'h10325476;
  localparam logic [31:0] INIT_E      = 32'hC3D2E1F0;
  localparam logic [31:0] RC_CHOOSE   = 32'h5A827999;
  localparam logic [31:0] RC_PARITY1  = 32'h6ED9EBA1;
  localparam logic [31:0] RC_MAJORITY = 32'h8F1BBCDC;
  localparam logic [31:0] RC_PARITY2  = 32'hCA62C1D6;
  localparam logic [6:0]  RND_LAST    = 7'h4F;
  localparam logic [6:0]  RND_G1      = 7'h14;
  localparam logic [6:0]  RND_G2      = 7'h28;
  localparam logic [6:0]  RND_G3      = 7'h3C;
  localparam logic [6:0]  RND_MSG     = 7'h10;
  localparam logic [6:0]  SECRET_LO   = 7'h00;
  localparam logic [6:0]  SECRET_HI   = 7'h0C;
  localparam logic [4:0]  FULL_FIRST  = 5'h08;
  localparam logic [4:0]  FULL_LAST   = 5'h1B;
  localparam logic [4:0]  PART_LAST   = 5'h1F;
  typedef enum logic [1:0] {
    SME_IDLE  = 2'b00,
    SME_ROUND = 2'b01,
    SME_WRITE = 2'b11
  } sme_state_t;
endpackage

// ### src/sme_word_mem.sv
// Sixteen-word memory holding the message window with a registered read port
`timescale 1ns/1ps
`default_nettype none
module sme_word_mem
  import sme_pkg::*;
(
  input  wire logic i_clk,     // System clock
  input  wire logic i_rst,     // Asynchronous reset, high
  sme_msg_if.mem    bus        // Word window port
);
  logic [31:0] mem [MSG_WORDS];
  logic [31:0] rd_q;

  // Write and registered read; no reset on storage
  always_ff @(posedge i_clk) begin
    if (bus.wr_en) begin
      mem[bus.wr_idx] <= bus.wr_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_q <= 32'h0;
    end else begin
      rd_q <= mem[bus.rd_idx];
    end
  end

  assign bus.rd_data = rd_q;
endmodule
`default_nettype wire
